// File: verilog/inductive_setup_pkg.sv
// Shared constants and types for the inductive channel setup block
`default_nettype none
package inductive_setup_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [4:0] IDX_RESULT0 = 5'h00;
    localparam logic [4:0] IDX_RESULT1 = 5'h02;
    localparam logic [4:0] IDX_CONV0 = 5'h08;
    localparam logic [4:0] IDX_CONV1 = 5'h09;
    localparam logic [4:0] IDX_SETTLE0 = 5'h10;
    localparam logic [4:0] IDX_SETTLE1 = 5'h11;
    localparam logic [4:0] IDX_DIV0 = 5'h14;
    localparam logic [4:0] IDX_DIV1 = 5'h15;
    localparam logic [4:0] IDX_FAULT = 5'h19;
    localparam logic [4:0] IDX_OPSET = 5'h1A;
    localparam logic [4:0] IDX_SCAN = 5'h1B;
    localparam logic [4:0] IDX_DRIVE0 = 5'h1E;
    localparam logic [4:0] IDX_DRIVE1 = 5'h1F;
    // Operating setup fields
    localparam int OP_CHAN_LSB = 14;
    localparam int OP_SLEEP = 13;
    localparam int OP_RP_OVR = 12;
    localparam int OP_ACT_SEL = 11;
    localparam int OP_AMP_DIS = 10;
    localparam int OP_REF_SRC = 9;
    // Scan setup fields
    localparam int SCAN_EN = 15;
    localparam int SCAN_SEQ_LSB = 13;
    localparam int GLITCH_LSB = 0;
    // Divider and drive fields
    localparam int DIV_FIN_LSB = 12;
    localparam int DIV_REF_MSB = 9;
    localparam int DRV_STEADY_LSB = 11;
    localparam int DRV_INIT_LSB = 6;
    // Reset values
    localparam logic [15:0] RST_OPSET = 16'h2801;
    localparam logic [15:0] RST_SCAN = 16'h0208;
    localparam logic [15:0] RST_CONV = 16'h0080;
    localparam logic [15:0] RST_SETTLE = 16'h0000;
    localparam logic [15:0] RST_DIV = 16'h0000;
    localparam logic [15:0] RST_FAULT = 16'h0000;
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    // Timing; the switch delay is given in ns and converted to divided reference periods
    localparam int PHASE_MULT = 16;
    localparam int SWITCH_TIME_NS = 1000;
    localparam int SWITCH_REF_MHZ = 20;
    localparam logic [20:0] SWITCH_TICKS = 21'(SWITCH_TIME_NS * SWITCH_REF_MHZ / 1000);
    typedef enum logic [1:0] {ST_SLEEP, ST_SETTLE, ST_CONVERT, ST_SWITCH} state_t;
    typedef struct packed {
        logic channel;
        logic converting;
        logic sleeping;
        logic auto_calibration;
        logic amplitude_correction;
        logic full_activation;
        logic external_reference;
        logic [2:0] glitch_filter;
        logic [4:0] drive_code;
    } sensor_ctrl_t;
endpackage
`default_nettype wire

// File: verilog/inductive_channel_setup.sv
// Setup registers and conversion sequencer of a two-channel inductive converter
// How it works
// R1: Powers up asleep, no conversions
// R2: Host writes operating setup last
// R3: Host may use input divider one
// R4: Host keeps divided reference above 4x
// R5: Divider register: input high, reference low
// R6: Settle lasts settle count times 16
// R7: Conversion lasts conversion count times 16
// R8: Channel switch adds about 1us
// R9: Host fits timing inside sample period
// R10: Fault reporting setup resets all disabled
// R11: Drive register: steady high, initial below
// R12: Scan enable converts channels in turn
// R13: Sequence b00 scans channels 0, 1
// R14: Glitch filter field selects bandwidth
// R15: Scan setup reads back as written
// R16: Active channel b00 selects channel 0
// R17: Clearing sleep starts conversions
// R18: Resistance override disables auto calibration
// R19: Activation select b0 gives full current
// R20: Amplitude correction disable bit honoured
// R21: Reference source b1 uses external clock
// R22: Results at indices 0x00 and 0x02
// R23: Result holds until next conversion ends
`default_nettype none
module inductive_channel_setup (
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [7:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic external_reference_input, // Reference clock pin, asynchronous
    input wire logic [1:0] sensor_in, // Squared tank oscillations, asynchronous
    output inductive_setup_pkg::sensor_ctrl_t sensor_ctrl // Controls toward the analog side
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Index decode shared by the read and write paths
    function automatic logic is_mapped(input logic [4:0] idx);
        return idx inside {inductive_setup_pkg::IDX_RESULT0, inductive_setup_pkg::IDX_RESULT1,
            inductive_setup_pkg::IDX_CONV0, inductive_setup_pkg::IDX_CONV1,
            inductive_setup_pkg::IDX_SETTLE0, inductive_setup_pkg::IDX_SETTLE1,
            inductive_setup_pkg::IDX_DIV0, inductive_setup_pkg::IDX_DIV1,
            inductive_setup_pkg::IDX_FAULT, inductive_setup_pkg::IDX_OPSET,
            inductive_setup_pkg::IDX_SCAN, inductive_setup_pkg::IDX_DRIVE0,
            inductive_setup_pkg::IDX_DRIVE1};
    endfunction

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [15:0] conv_count [2];
    logic [15:0] settle_count [2];
    logic [15:0] dividers [2];
    logic [15:0] drive_level [2];
    logic [15:0] result [2];
    logic [15:0] fault_setup;
    logic [15:0] opset;
    logic [15:0] scan_setup;
    logic [4:0] aw_idx;
    logic aw_out;
    logic wr_go;
    logic rd_ok;
    logic [20:0] conv_steps;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_wr;
    logic wr_refused;
    logic wr_ro;
    logic [15:0] rd_word;
    inductive_setup_pkg::state_t state;
    logic cur_ch;
    logic next_ch;
    logic [20:0] phase_cnt;
    logic [20:0] target;
    logic [9:0] ref_cnt;
    logic [9:0] ref_div;
    logic [3:0] fin_cnt;
    logic [3:0] fin_div;
    logic [15:0] acc;
    logic src_tick;
    logic step;
    logic phase_end;
    logic sens_tick;
    logic [2:0] ext_sync;
    logic [2:0] sens_sync [2];
    logic [1:0] sens_edge;

    // Write channel: address and data are held until both are here
    assign do_wr = !awready && !wready && !bvalid;
    // An out-of-range address must not alias onto a real register
    assign wr_go = do_wr && !aw_out;
    assign wr_ro = aw_idx inside {inductive_setup_pkg::IDX_RESULT0,
                                  inductive_setup_pkg::IDX_RESULT1};
    // Setup is frozen unless asleep; only the operating setup can stop it
    assign wr_refused = state != inductive_setup_pkg::ST_SLEEP
                        && aw_idx != inductive_setup_pkg::IDX_OPSET; // R2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_idx <= 5'h00;
            aw_out <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_idx <= awaddr[6:2];
                aw_out <= awaddr[7];
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_wr) begin
                bvalid <= 1'b1;
                if (!is_mapped(aw_idx) || aw_out) begin
                    bresp <= RESP_DECERR;
                end else if (wr_ro || wr_refused) begin
                    bresp <= RESP_SLVERR;
                end else begin
                    bresp <= RESP_OKAY;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Per-channel setup registers
    for (genvar c = 0; c < 2; c++) begin : g_chan_regs
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                conv_count[c] <= inductive_setup_pkg::RST_CONV;
                settle_count[c] <= inductive_setup_pkg::RST_SETTLE;
                dividers[c] <= inductive_setup_pkg::RST_DIV;
                drive_level[c] <= inductive_setup_pkg::RST_DRIVE;
            end else if (wr_go && !wr_refused) begin
                if (aw_idx == inductive_setup_pkg::IDX_CONV0 + 5'(c)) begin
                    conv_count[c] <= merge(conv_count[c], w_data, w_strb);
                end
                if (aw_idx == inductive_setup_pkg::IDX_SETTLE0 + 5'(c)) begin
                    settle_count[c] <= merge(settle_count[c], w_data, w_strb);
                end
                if (aw_idx == inductive_setup_pkg::IDX_DIV0 + 5'(c)) begin
                    dividers[c] <= merge(dividers[c], w_data, w_strb); // R5
                end
                if (aw_idx == inductive_setup_pkg::IDX_DRIVE0 + 5'(c)) begin
                    drive_level[c] <= merge(drive_level[c], w_data, w_strb); // R11
                end
            end
        end
    end

    // Global setup registers; sleep comes out of reset set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_setup <= inductive_setup_pkg::RST_FAULT; // R10
            opset <= inductive_setup_pkg::RST_OPSET; // R1
            scan_setup <= inductive_setup_pkg::RST_SCAN;
        end else if (wr_go) begin
            if (aw_idx == inductive_setup_pkg::IDX_OPSET) begin
                opset <= merge(opset, w_data, w_strb); // R17
            end
            if (aw_idx == inductive_setup_pkg::IDX_FAULT && !wr_refused) begin
                fault_setup <= merge(fault_setup, w_data, w_strb);
            end
            if (aw_idx == inductive_setup_pkg::IDX_SCAN && !wr_refused) begin
                scan_setup <= merge(scan_setup, w_data, w_strb); // R15
            end
        end
    end

    // Read mux; results sit at indices 0x00 and 0x02
    always_comb begin
        unique case (araddr[6:2])
            inductive_setup_pkg::IDX_RESULT0: rd_word = result[0]; // R22
            inductive_setup_pkg::IDX_RESULT1: rd_word = result[1]; // R22
            inductive_setup_pkg::IDX_CONV0: rd_word = conv_count[0];
            inductive_setup_pkg::IDX_CONV1: rd_word = conv_count[1];
            inductive_setup_pkg::IDX_SETTLE0: rd_word = settle_count[0];
            inductive_setup_pkg::IDX_SETTLE1: rd_word = settle_count[1];
            inductive_setup_pkg::IDX_DIV0: rd_word = dividers[0];
            inductive_setup_pkg::IDX_DIV1: rd_word = dividers[1];
            inductive_setup_pkg::IDX_FAULT: rd_word = fault_setup;
            inductive_setup_pkg::IDX_OPSET: rd_word = opset;
            inductive_setup_pkg::IDX_SCAN: rd_word = scan_setup;
            inductive_setup_pkg::IDX_DRIVE0: rd_word = drive_level[0];
            inductive_setup_pkg::IDX_DRIVE1: rd_word = drive_level[1];
            default: rd_word = 16'h0000;
        endcase
    end

    // Unmapped reads answer zero data
    assign rd_ok = is_mapped(araddr[6:2]) && !araddr[7];

    // Read channel: one-cycle answer, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_ok ? rd_word : 16'h0000};
            rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Pin synchronisers; stage 2 feeds the edge detectors
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_reference_input};
        end
    end
    for (genvar c = 0; c < 2; c++) begin : g_sens_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sens_sync[c] <= 3'h0;
            end else begin
                sens_sync[c] <= {sens_sync[c][1:0], sensor_in[c]};
            end
        end
        assign sens_edge[c] = sens_sync[c][1] && !sens_sync[c][2];
    end

    // Reference and sensor prescalers for the channel in hand
    assign src_tick = opset[inductive_setup_pkg::OP_REF_SRC] ? (ext_sync[1] && !ext_sync[2])
                                                             : 1'b1; // R21
    assign ref_div = (dividers[cur_ch][inductive_setup_pkg::DIV_REF_MSB:0] == 10'h000) ? 10'h001
                     : dividers[cur_ch][inductive_setup_pkg::DIV_REF_MSB:0]; // R5
    assign fin_div = (dividers[cur_ch][15:inductive_setup_pkg::DIV_FIN_LSB] == 4'h0) ? 4'h1
                     : dividers[cur_ch][15:inductive_setup_pkg::DIV_FIN_LSB];
    assign step = src_tick && (ref_cnt >= ref_div - 10'h001);
    assign sens_tick = sens_edge[cur_ch] && (fin_cnt >= fin_div - 4'h1);

    // Length of the current phase in divided reference periods
    always_comb begin
        unique case (state)
            inductive_setup_pkg::ST_SETTLE:
                target = {1'b0, settle_count[cur_ch], 4'h0}; // R6
            inductive_setup_pkg::ST_CONVERT:
                target = {1'b0, conv_count[cur_ch], 4'h0}; // R7
            inductive_setup_pkg::ST_SWITCH: target = inductive_setup_pkg::SWITCH_TICKS; // R8
            inductive_setup_pkg::ST_SLEEP: target = 21'h00_0000;
        endcase
    end
    assign phase_end = step && (phase_cnt + 21'h00_0001 >= target);

    // Channel after a conversion: alternate when scanning, else the active one
    assign next_ch = scan_setup[inductive_setup_pkg::SCAN_EN] ? !cur_ch // R12 R13
                     : opset[inductive_setup_pkg::OP_CHAN_LSB]; // R16

    // Prescaler counters
    always_ff @(posedge aclk) begin
        if (!aresetn || state == inductive_setup_pkg::ST_SLEEP) begin
            ref_cnt <= 10'h000;
            fin_cnt <= 4'h0;
        end else begin
            if (src_tick) begin
                ref_cnt <= step ? 10'h000 : ref_cnt + 10'h001;
            end
            if (sens_edge[cur_ch]) begin
                fin_cnt <= sens_tick ? 4'h0 : fin_cnt + 4'h1;
            end
        end
    end

    // Sequencer; a sleep write stops it at once, mid-conversion results are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= inductive_setup_pkg::ST_SLEEP; // R1
            cur_ch <= 1'b0;
            phase_cnt <= 21'h00_0000;
            acc <= 16'h0000;
        end else if (opset[inductive_setup_pkg::OP_SLEEP]) begin
            state <= inductive_setup_pkg::ST_SLEEP;
            phase_cnt <= 21'h00_0000;
        end else begin
            if (phase_end || state == inductive_setup_pkg::ST_SLEEP) begin
                phase_cnt <= 21'h00_0000;
            end else if (step) begin
                phase_cnt <= phase_cnt + 21'h00_0001;
            end
            if (state != inductive_setup_pkg::ST_CONVERT || phase_end) begin
                acc <= 16'h0000;
            end else if (sens_tick && acc != 16'hFFFF) begin
                acc <= acc + 16'h0001;
            end
            unique case (state)
                inductive_setup_pkg::ST_SLEEP: begin
                    state <= inductive_setup_pkg::ST_SETTLE; // R17
                    cur_ch <= scan_setup[inductive_setup_pkg::SCAN_EN] ? 1'b0
                              : opset[inductive_setup_pkg::OP_CHAN_LSB]; // R13 R16
                end
                inductive_setup_pkg::ST_SETTLE: begin
                    if (phase_end) state <= inductive_setup_pkg::ST_CONVERT; // R6
                end
                inductive_setup_pkg::ST_CONVERT: begin
                    if (phase_end && next_ch != cur_ch) begin
                        state <= inductive_setup_pkg::ST_SWITCH; // R12
                        cur_ch <= next_ch;
                    end
                end
                inductive_setup_pkg::ST_SWITCH: begin
                    if (phase_end) state <= inductive_setup_pkg::ST_SETTLE; // R8
                end
            endcase
        end
    end

    // Results update only when their channel finishes a conversion
    for (genvar c = 0; c < 2; c++) begin : g_results
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                result[c] <= 16'h0000;
            end else if (state == inductive_setup_pkg::ST_CONVERT && phase_end
                         && cur_ch == 1'(c) && !opset[inductive_setup_pkg::OP_SLEEP]) begin
                result[c] <= acc; // R23
            end
        end
    end

    // Analog controls; initial drive applies while the tank settles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sensor_ctrl <= '0;
        end else begin
            sensor_ctrl.channel <= cur_ch;
            sensor_ctrl.converting <= state == inductive_setup_pkg::ST_CONVERT;
            sensor_ctrl.sleeping <= state == inductive_setup_pkg::ST_SLEEP;
            sensor_ctrl.auto_calibration <= !opset[inductive_setup_pkg::OP_RP_OVR]; // R18
            sensor_ctrl.amplitude_correction <= !opset[inductive_setup_pkg::OP_AMP_DIS]; // R20
            sensor_ctrl.full_activation <= !opset[inductive_setup_pkg::OP_ACT_SEL]; // R19
            sensor_ctrl.external_reference <= opset[inductive_setup_pkg::OP_REF_SRC]; // R21
            sensor_ctrl.glitch_filter <= scan_setup[inductive_setup_pkg::GLITCH_LSB +: 3]; // R14
            sensor_ctrl.drive_code <= state == inductive_setup_pkg::ST_SETTLE
                ? drive_level[cur_ch][inductive_setup_pkg::DRV_INIT_LSB +: 5]
                : drive_level[cur_ch][inductive_setup_pkg::DRV_STEADY_LSB +: 5]; // R11
        end
    end

    // Separate count of reference periods per conversion, for the length check
    always_ff @(posedge aclk) begin
        if (!aresetn || state != inductive_setup_pkg::ST_CONVERT || phase_end) begin
            conv_steps <= 21'h00_0000;
        end else if (step) begin
            conv_steps <= conv_steps + 21'h00_0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_conv_done;
        state == inductive_setup_pkg::ST_CONVERT && phase_end
            && !opset[inductive_setup_pkg::OP_SLEEP];
    endsequence
    sequence s_wake;
        state == inductive_setup_pkg::ST_SLEEP && !opset[inductive_setup_pkg::OP_SLEEP];
    endsequence

    property p_sleep_idle;
        opset[inductive_setup_pkg::OP_SLEEP] ##1 opset[inductive_setup_pkg::OP_SLEEP]
            |=> sensor_ctrl.sleeping && !sensor_ctrl.converting;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("converting while asleep"); // R1
    property p_fault_reset;
        $past(!aresetn) |-> fault_setup == 16'h0000 && opset[inductive_setup_pkg::OP_SLEEP];
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("bad reset setup"); // R10
    property p_wake;
        s_wake |=> state == inductive_setup_pkg::ST_SETTLE ##1 sensor_ctrl.drive_code
            == drive_level[$past(cur_ch)][inductive_setup_pkg::DRV_INIT_LSB +: 5];
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not start settling"); // R17
    property p_conv_len;
        s_conv_done ##0 conv_count[cur_ch] != 16'h0000
            |-> conv_steps + 21'h00_0001 == {1'b0, conv_count[cur_ch], 4'h0};
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // R7
    property p_scan_alt;
        s_conv_done ##0 scan_setup[inductive_setup_pkg::SCAN_EN]
            |=> cur_ch != $past(cur_ch) ##0 state == inductive_setup_pkg::ST_SWITCH;
    endproperty
    a_scan_alt: assert property (p_scan_alt) else $error("scan did not switch"); // R12
    property p_single_ch0;
        s_conv_done ##0 !scan_setup[inductive_setup_pkg::SCAN_EN]
            ##0 !opset[inductive_setup_pkg::OP_CHAN_LSB] |=> !cur_ch;
    endproperty
    a_single_ch0: assert property (p_single_ch0) else $error("wrong single channel"); // R16
    property p_result_hold;
        !(state == inductive_setup_pkg::ST_CONVERT && phase_end && !cur_ch)
            |=> $stable(result[0]);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed early"); // R23
    property p_ref_src;
        !opset[inductive_setup_pkg::OP_REF_SRC] ##1 !opset[inductive_setup_pkg::OP_REF_SRC]
            |-> !sensor_ctrl.external_reference && src_tick;
    endproperty
    a_ref_src: assert property (p_ref_src) else $error("reference source wrong"); // R21
    property p_refuse;
        wr_go && wr_refused && aw_idx == inductive_setup_pkg::IDX_SCAN
            |=> $stable(scan_setup) ##0 bresp == RESP_SLVERR;
    endproperty
    a_refuse: assert property (p_refuse) else $error("setup changed while active"); // R2
    property p_switch_len;
        state == inductive_setup_pkg::ST_SWITCH && phase_end |-> phase_cnt == 21'd19;
    endproperty
    a_switch_len: assert property (p_switch_len) else $error("switch delay wrong"); // R8
endmodule // inductive_channel_setup
`default_nettype wire

// File: tb/sensor_tank_model.sv
// Behavioural sensor tanks and external reference clock on the far side
`default_nettype none
module sensor_tank_model (
    output logic ref_clk, // External reference, 40 MHz, free running
    output logic tank0, // Channel 0 tank, 2.5 MHz
    output logic tank1 // Channel 1 tank, 1.25 MHz
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reference divided by two gives 20 MHz, above four times either tank
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Both tanks stay under 8.75 MHz, so the input divider can stay at one
    initial begin
        tank0 = 1'b0;
        forever #200 tank0 = ~tank0;
    end
    // Half the rate of channel 0, so swapped result addresses would show
    initial begin
        tank1 = 1'b0;
        forever #400 tank1 = ~tank1;
    end
endmodule // sensor_tank_model
`default_nettype wire

// File: tb/inductive_channel_setup_tb.sv
// Self-checking bench for the inductive channel setup block
`default_nettype none
module inductive_channel_setup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Response readies stay high, so back-to-back calls never toggle them
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic arvalid = 1'b0, rready = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ref_clk, t0, t1;
    logic [1:0] bresp, rresp, r, seen;
    logic [31:0] rdata, d, keep;
    inductive_setup_pkg::sensor_ctrl_t sc;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] ad[9] = '{8'h20, 8'h24, 8'h40, 8'h44, 8'h50, 8'h54, 8'h78, 8'h7C, 8'h6C};
    logic [15:0] vl[9] = '{16'h0004, 16'h0004, 16'h000A, 16'h000A, 16'h1002, 16'h1002,
        16'h9000, 16'h9000, 16'h820C};
    inductive_channel_setup u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .external_reference_input(ref_clk),
        .sensor_in({t1, t0}), .sensor_ctrl(sc));
    sensor_tank_model u_tank (.ref_clk, .tank0(t0), .tank1(t1));
    // System clock, 100 MHz
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        awaddr <= a;
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        r = rresp;
        d = rdata;
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard, well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        conclude();
    end
    // Main sequence; operating setup goes last, since setup is locked once awake
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h68);
        chk("opset", 32'h0000_2801, d);
        chk("sleeping", 32'h0000_0001, {31'h0, sc.sleeping});
        rd(8'h64);
        chk("fault", 32'h0000_0000, d);
        for (int i = 0; i < 9; i++) begin
            wr(ad[i], vl[i]);
            chk("wresp", 32'h0000_0000, {30'h0, r});
            rd(ad[i]);
            chk("readback", {16'h0000, vl[i]}, d);
        end
        wr(8'h00, 16'h1234);
        chk("result write", 32'h0000_0002, {30'h0, r});
        wr(8'h80, 16'h0001);
        chk("unmapped write", 32'h0000_0003, {30'h0, r});
        rd(8'h80);
        chk("unmapped read", 32'h0000_0003, {30'h0, r});
        chk("unmapped data", 32'h0000_0000, d);
        wr(8'h68, 16'h1601);
        repeat (3) @(posedge aclk);
        chk("ctrl", 32'h0000_001C, {24'h0, sc.sleeping, sc.auto_calibration,
            sc.amplitude_correction, sc.full_activation, sc.external_reference,
            sc.glitch_filter});
        wr(8'h40, 16'h0001);
        chk("awake write", 32'h0000_0002, {30'h0, r});
        wr(8'h6C, 16'h0000);
        chk("awake scan write", 32'h0000_0002, {30'h0, r});
        seen = 2'b00;
        repeat (4000) begin
            @(posedge aclk);
            seen[sc.channel] = 1'b1;
        end
        chk("scan", 32'h0000_0003, {30'h0, seen});
        rd(8'h00);
        chk("result0", 32'h0000_0001, {31'h0, d >= 7 && d <= 9});
        rd(8'h08);
        chk("result1", 32'h0000_0001, {31'h0, d >= 3 && d <= 5});
        rd(8'h40);
        chk("settle kept", 32'h0000_000A, d);
        rd(8'h6C);
        chk("scan kept", 32'h0000_820C, d);
        // Sleep again, then continuous channel 0 with the same filter
        wr(8'h68, 16'h3601);
        repeat (3) @(posedge aclk);
        chk("asleep", 32'h0000_0001, {31'h0, sc.sleeping});
        wr(8'h6C, 16'h020C);
        rd(8'h6C);
        chk("single scan", 32'h0000_020C, d);
        rd(8'h08);
        keep = d;
        wr(8'h68, 16'h1601);
        repeat (3) @(posedge aclk);
        seen = 2'b00;
        repeat (2500) begin
            @(posedge aclk);
            seen[sc.channel] = 1'b1;
        end
        chk("single channel", 32'h0000_0001, {30'h0, seen});
        rd(8'h08);
        chk("result1 held", keep, d);
        rd(8'h00);
        chk("result0 single", 32'h0000_0001, {31'h0, d >= 7 && d <= 9});
        conclude();
    end
endmodule // inductive_channel_setup_tb
`default_nettype wire
